/* File: design/urx_pkg.sv */
package urx_pkg;
  // Register addresses in the special function space
  localparam logic [7:0] ADDR_STATUS = 8'h00_E2;
  localparam logic [7:0] ADDR_DATA = 8'h00_E3;
  localparam logic [7:0] ADDR_CONTROL = 8'h00_E4;
  localparam logic [7:0] ADDR_FLAGS = 8'h00_E5;
  localparam logic [7:0] ADDR_EPSEL = 8'h00_F1;
  localparam logic [7:0] ADDR_EPCFG = 8'h00_F2;
  // Flag register fields
  localparam int FLG_FIF_HI = 7;
  localparam int FLG_FIF_LO = 6;
  localparam int FLG_EMP = 3;
  localparam int FLG_FULL = 2;
  localparam int FLG_URF = 1;
  localparam int FLG_OVF = 0;
  localparam logic [7:0] FLG_RESET = 8'h00_08;
  // Control register fields
  localparam int CTL_FLUSH = 7;
  localparam int CTL_FFRC = 4;
  localparam int CTL_ISO = 3;
  localparam int CTL_ARM = 2;
  localparam int CTL_ADV = 1;
  localparam int CTL_REV = 0;
  localparam logic [7:0] CTL_RESET = 8'h00_04;
  // Status register fields
  localparam int ST_SEQ = 7;
  localparam int ST_SETUP = 6;
  localparam int ST_START_OVERWRITE_FLAG = 5;
  localparam int ST_END_OVERWRITE_FLAG = 4;
  localparam int ST_SOVW = 3;
  localparam int ST_VOID = 2;
  // Endpoint configuration fields
  localparam int CFG_SPM = 0;
  localparam int CFG_STALL = 1;
  localparam int CFG_CTRL = 2;
  // Geometry
  localparam int NUM_EP = 4;
  localparam int EP_W = 2;
  localparam int DEPTH_W = 5;
  localparam int DEPTH = 32;
  typedef enum logic [2:0] {
    TOK_NONE = 3'b001,
    TOK_SETUP = 3'b010,
    TOK_DATA = 3'b100
  } urx_tok_e;
  // Events reported by the interface unit
  typedef struct packed {
    logic wr;
    logic [7:0] data;
    logic cnt_wr;
    logic ack;
    logic nak;
    logic setup_tok;
    logic out_tok;
    logic handshake;
    logic sof;
  } urx_fiu_s;
endpackage

/* File: design/urx_index_fsm.sv */
`timescale 1ns/1ps
`default_nettype none
module urx_index_fsm
  import urx_pkg::*;
(
  input wire logic [1:0] fif_in,
  input wire logic add_in,
  input wire logic remove_in,
  input wire logic single_in,
  output logic [1:0] fif_out,
  output logic add_blocked_out
);
  logic [1:0] after_add;
  logic [1:0] after_rem;
  // Single packet mode never goes beyond one packet
  assign add_blocked_out = single_in ? fif_in[0] : (fif_in == 2'b11);
  assign after_add = single_in ? 2'b01 :
                     (fif_in == 2'b00) ? 2'b01 :
                     (fif_in == 2'b01) ? 2'b11 :
                     (fif_in == 2'b10) ? 2'b11 : fif_in;
  // 11 drops the older packet, keeping the newer one
  assign after_rem = (fif_in == 2'b11) ? 2'b10 : 2'b00;
  always_comb
  begin
    fif_out = fif_in;
    if (add_in && !add_blocked_out)
    begin
      fif_out = after_add;
    end
    if (remove_in)
    begin
      fif_out = (add_in && !add_blocked_out) ? 2'b01 : after_rem;
    end
    if (single_in)
    begin
      fif_out = {1'b0, fif_out[1] | fif_out[0]};
    end
  end
endmodule
`default_nettype wire

/* File: design/urx_fifo.sv */
// Contract
// - Advance-marker moves marker, self-clears, gated
// - Reverse-pointer rewinds write pointer, self-clears
// - Data write/read advance pointers
// - Index flags add on count, drop on read-complete
// - Dual mode follows next-state table
// - Single mode index only 00 or 01
// - Isochronous index, overrun and void updates wait for frame start
// - Empty flag tracks live empty state
// - Full flag tracks rolled-over equality
// - Underrun sticky, read pointer locked
// - Overrun sticky, write pointer locked
// - Setup flag forces NAK on OUT tokens
// - Setup locks FIFO until end-overwrite
// - Void flag on locked or stalled reception; stall alone sets no void on non-iso control endpoints
// - Auto management ignores manual controls
// - Flush empties FIFO, flags to reset
`timescale 1ns/1ps
`default_nettype none
module urx_fifo
  import urx_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Core register port
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  // Interface unit events, for the endpoint given by FIU_EP_IN
  input wire logic [EP_W-1:0] FIU_EP_IN,
  input wire urx_fiu_s FIU_IN,
  output logic NAK_OUT
);
  localparam int PW = DEPTH_W + 1;
  logic [7:0] mem [NUM_EP][DEPTH];
  logic [PW-1:0] wp_reg [NUM_EP];
  logic [PW-1:0] rp_reg [NUM_EP];
  logic [PW-1:0] wm_reg [NUM_EP];
  logic [1:0] fif_reg [NUM_EP];
  logic [NUM_EP-1:0] urf_reg, ovf_reg, pend_ovf_reg, pend_add_reg;
  logic [NUM_EP-1:0] seq_reg, setup_reg, start_overwrite_flag_reg, end_overwrite_flag_reg, void_reg;
  logic [NUM_EP-1:0] pend_void_reg, pend_void_val_reg;
  logic [7:0] ctl_reg [NUM_EP];
  logic [7:0] cfg_reg [NUM_EP];
  logic [EP_W-1:0] sel_reg;
  logic [7:0] rdata_next;
  logic nak_next;

  function automatic logic is_empty(input logic [PW-1:0] w, r, m);
    return (w == r) && (w == m) && !w[PW-1] && !r[PW-1];
  endfunction
  function automatic logic is_full(input logic [PW-1:0] w, r);
    return (w[PW-1] != r[PW-1]) && (w[DEPTH_W-1:0] == r[DEPTH_W-1:0]);
  endfunction

  // Selected-endpoint views for the core side, FIU_EP_IN views for the bus side
  wire [EP_W-1:0] s = sel_reg;
  wire [EP_W-1:0] f = FIU_EP_IN;
  wire s_empty = is_empty(wp_reg[s], rp_reg[s], wm_reg[s]);
  wire s_full = is_full(wp_reg[s], rp_reg[s]);
  wire s_locked = start_overwrite_flag_reg[s] && !end_overwrite_flag_reg[s];
  wire f_locked = start_overwrite_flag_reg[f] && !end_overwrite_flag_reg[f];
  wire f_iso = ctl_reg[f][CTL_ISO];
  wire f_full = is_full(wp_reg[f], rp_reg[f]);
  wire wr_status = SFR_WR_IN && (SFR_ADDR_IN == ADDR_STATUS);
  wire wr_ctl = SFR_WR_IN && (SFR_ADDR_IN == ADDR_CONTROL);
  wire wr_flags = SFR_WR_IN && (SFR_ADDR_IN == ADDR_FLAGS);
  wire rd_data = SFR_RD_IN && (SFR_ADDR_IN == ADDR_DATA);
  wire [7:0] ctl_s = ctl_reg[s];
  wire ctl_manual = !ctl_s[CTL_ARM] && !ctl_s[CTL_FLUSH];
  wire do_adv = ctl_manual && ctl_s[CTL_ADV] && !ctl_s[CTL_REV];
  wire do_rev = ctl_manual && ctl_s[CTL_REV] && !ctl_s[CTL_ADV];
  wire do_flush = ctl_s[CTL_FLUSH];
  wire do_ffrc = ctl_s[CTL_FFRC];
  // The setup lock freezes only the core's view; new setup bytes must still land
  wire f_byte_ok = FIU_IN.wr && !f_full;
  wire f_add_now = FIU_IN.cnt_wr && !f_iso;
  wire f_add_sof = FIU_IN.sof && pend_add_reg[f];
  // ARM: acknowledged packet advances the marker
  wire arm_adv = ctl_reg[f][CTL_ARM] && FIU_IN.ack;
  wire arm_rev = ctl_reg[f][CTL_ARM] && FIU_IN.nak && !f_iso;
  logic [1:0] fif_s_next, fif_f_next;
  logic blk_s, blk_f;

  urx_index_fsm u_idx_s (
    .fif_in(fif_reg[s]),
    .add_in(do_adv && (f != s || !(f_add_now || f_add_sof))),
    .remove_in(do_ffrc),
    .single_in(cfg_reg[s][CFG_SPM]),
    .fif_out(fif_s_next),
    .add_blocked_out(blk_s)
  );
  urx_index_fsm u_idx_f (
    .fif_in((f == s) ? fif_s_next : fif_reg[f]),
    .add_in(f_add_now || f_add_sof),
    .remove_in(1'b0),
    .single_in(cfg_reg[f][CFG_SPM]),
    .fif_out(fif_f_next),
    .add_blocked_out(blk_f)
  );

  assign rdata_next =
    (SFR_ADDR_IN == ADDR_DATA) ? ((s_empty || s_locked) ? 8'h00_00 : mem[s][rp_reg[s][DEPTH_W-1:0]]) :
    (SFR_ADDR_IN == ADDR_FLAGS) ? {fif_reg[s], 2'b00, s_empty, s_full, urf_reg[s], ovf_reg[s]} :
    (SFR_ADDR_IN == ADDR_STATUS) ? {seq_reg[s], setup_reg[s], start_overwrite_flag_reg[s], end_overwrite_flag_reg[s],
                                    1'b0, void_reg[s], 2'b00} :
    (SFR_ADDR_IN == ADDR_CONTROL) ? ctl_s :
    (SFR_ADDR_IN == ADDR_EPSEL) ? {6'h00, sel_reg} :
    (SFR_ADDR_IN == ADDR_EPCFG) ? cfg_reg[s] : 8'h00_00;
  // Setup pending holds off data tokens even on a stalled endpoint
  assign nak_next = (FIU_IN.out_tok && (setup_reg[f] || f_locked)) ||
                    (FIU_IN.out_tok && cfg_reg[f][CFG_STALL] && !setup_reg[f]);

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      SFR_RDATA_OUT <= 8'h00_00;
      NAK_OUT <= 1'b0;
    end
    else
    begin
      SFR_RDATA_OUT <= rdata_next;
      NAK_OUT <= nak_next;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      sel_reg <= '0;
    end
    else if (SFR_WR_IN && SFR_ADDR_IN == ADDR_EPSEL)
    begin
      sel_reg <= SFR_WDATA_IN[EP_W-1:0];
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (f_byte_ok)
    begin
      mem[f][wp_reg[f][DEPTH_W-1:0]] <= FIU_IN.data;
    end
  end

  // Per-endpoint state: core actions act on sel, bus events on FIU_EP_IN
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      for (int i = 0; i < NUM_EP; i++)
      begin
        wp_reg[i] <= '0;
        rp_reg[i] <= '0;
        wm_reg[i] <= '0;
        fif_reg[i] <= 2'b00;
        ctl_reg[i] <= CTL_RESET;
        cfg_reg[i] <= 8'h00_00;
      end
      urf_reg <= '0;
      ovf_reg <= '0;
      pend_ovf_reg <= '0;
      pend_add_reg <= '0;
      seq_reg <= '0;
      setup_reg <= '0;
      start_overwrite_flag_reg <= '0;
      end_overwrite_flag_reg <= '0;
      void_reg <= '0;
      pend_void_reg <= '0;
      pend_void_val_reg <= '0;
    end
    else
    begin
      // ADV, REV, FFRC and FLUSH self-clear after one cycle of action; ARM and ISO hold
      ctl_reg[s][CTL_ADV] <= 1'b0;
      ctl_reg[s][CTL_REV] <= 1'b0;
      ctl_reg[s][CTL_FFRC] <= 1'b0;
      ctl_reg[s][CTL_FLUSH] <= 1'b0;
      if (wr_ctl)
      begin
        ctl_reg[s] <= SFR_WDATA_IN & 8'h00_BF;
      end
      if (SFR_WR_IN && SFR_ADDR_IN == ADDR_EPCFG)
      begin
        cfg_reg[s] <= SFR_WDATA_IN;
      end
      if (do_adv)
      begin
        wm_reg[s] <= wp_reg[s];
      end
      if (do_rev)
      begin
        wp_reg[s] <= wm_reg[s];
      end
      fif_reg[s] <= fif_s_next;
      // Reads from an empty FIFO lock the pointer and latch underrun
      if (rd_data && !s_locked)
      begin
        if (s_empty)
        begin
          urf_reg[s] <= 1'b1;
        end
        else
        begin
          rp_reg[s] <= rp_reg[s] + PW'(1);
        end
      end
      if (wr_flags)
      begin
        if (!SFR_WDATA_IN[FLG_URF])
        begin
          urf_reg[s] <= 1'b0;
        end
        if (!SFR_WDATA_IN[FLG_OVF])
        begin
          ovf_reg[s] <= 1'b0;
        end
      end
      if (wr_status)
      begin
        if (SFR_WDATA_IN[ST_SOVW])
        begin
          seq_reg[s] <= SFR_WDATA_IN[ST_SEQ];
        end
        setup_reg[s] <= setup_reg[s] & SFR_WDATA_IN[ST_SETUP];
        end_overwrite_flag_reg[s] <= SFR_WDATA_IN[ST_END_OVERWRITE_FLAG];
      end
      // Bus-side events; set wins over any core clear above
      if (f_byte_ok)
      begin
        wp_reg[f] <= wp_reg[f] + PW'(1);
      end
      if (arm_adv)
      begin
        wm_reg[f] <= wp_reg[f] + PW'(f_byte_ok);
      end
      if (arm_rev)
      begin
        wp_reg[f] <= wm_reg[f];
      end
      if (FIU_IN.cnt_wr && f_iso)
      begin
        pend_add_reg[f] <= 1'b1;
      end
      if (f_add_now || f_add_sof)
      begin
        fif_reg[f] <= fif_f_next;
        pend_add_reg[f] <= FIU_IN.cnt_wr && f_iso && !FIU_IN.sof;
      end
      if ((FIU_IN.wr && f_full) || ((f_add_now || f_add_sof) && blk_f))
      begin
        if (f_iso)
        begin
          pend_ovf_reg[f] <= 1'b1;
        end
        else
        begin
          ovf_reg[f] <= 1'b1;
        end
      end
      if (FIU_IN.sof && pend_ovf_reg[f])
      begin
        ovf_reg[f] <= 1'b1;
        pend_ovf_reg[f] <= 1'b0;
      end
      if (FIU_IN.ack || FIU_IN.nak)
      begin
        seq_reg[f] <= FIU_IN.ack ? ~seq_reg[f] : seq_reg[f];
        if (f_iso)
        begin
          pend_void_reg[f] <= 1'b1;
          pend_void_val_reg[f] <= f_locked || cfg_reg[f][CFG_STALL];
        end
        else
        begin
          void_reg[f] <= f_locked || (cfg_reg[f][CFG_STALL] && !cfg_reg[f][CFG_CTRL]);
        end
      end
      if (FIU_IN.sof && pend_void_reg[f])
      begin
        void_reg[f] <= pend_void_val_reg[f];
        pend_void_reg[f] <= 1'b0;
      end
      if (FIU_IN.setup_tok && cfg_reg[f][CFG_CTRL])
      begin
        setup_reg[f] <= 1'b1;
        start_overwrite_flag_reg[f] <= 1'b1;
        end_overwrite_flag_reg[f] <= 1'b0;
        rp_reg[f] <= '0;
        wp_reg[f] <= '0;
        wm_reg[f] <= '0;
        fif_reg[f] <= 2'b00;
        ovf_reg[f] <= 1'b0;
      end
      if (FIU_IN.handshake && start_overwrite_flag_reg[f])
      begin
        start_overwrite_flag_reg[f] <= 1'b0;
        end_overwrite_flag_reg[f] <= 1'b1;
      end
      if (do_flush)
      begin
        wp_reg[s] <= '0;
        rp_reg[s] <= '0;
        wm_reg[s] <= '0;
        fif_reg[s] <= 2'b00;
        urf_reg[s] <= 1'b0;
        ovf_reg[s] <= 1'b0;
        pend_ovf_reg[s] <= 1'b0;
        pend_add_reg[s] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/urx_fiu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module urx_fiu_model
  import urx_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Events towards the block
  output var urx_fiu_s fiu_out
);
  logic [7:0] last_reg = 8'h00;
  initial fiu_out = '0;
  // Idle data is the inverse of the last byte, so stale data never looks valid
  task automatic ev(input urx_fiu_s e);
    urx_fiu_s v;
    v = e;
    if (e.wr)
      last_reg = e.data;
    else
      v.data = ~last_reg;
    @(posedge clk_in);
    #1;
    fiu_out = v;
    @(posedge clk_in);
    #1;
    v = '0;
    v.data = ~last_reg;
    fiu_out = v;
  endtask
endmodule
`default_nettype wire

/* File: tb/urx_fifo_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module urx_fifo_checker
  import urx_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Register port
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  // Bus events
  input wire logic [EP_W-1:0] FIU_EP_IN,
  input wire urx_fiu_s FIU_IN,
  input wire logic NAK_OUT
);
  logic [EP_W-1:0] sel_reg;
  logic [NUM_EP-1:0][2:0] cfg_reg;
  logic [NUM_EP-1:0] cfg_v_reg;
  logic [NUM_EP-1:0][1:0] mode_reg;
  wire unmapped = !(SFR_ADDR_IN inside {[ADDR_STATUS:ADDR_FLAGS], ADDR_EPSEL, ADDR_EPCFG});
  wire wr_ctl = SFR_WR_IN && SFR_ADDR_IN == ADDR_CONTROL;
  wire wr_cfg = SFR_WR_IN && SFR_ADDR_IN == ADDR_EPCFG;
  // Shadow only what firmware writes; config is trusted once written
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      sel_reg <= '0;
      cfg_v_reg <= '0;
      cfg_reg <= '0;
      mode_reg <= {NUM_EP{2'b01}};
    end
    else
    begin
      if (SFR_WR_IN && SFR_ADDR_IN == ADDR_EPSEL)
        sel_reg <= SFR_WDATA_IN[EP_W-1:0];
      if (wr_cfg)
        cfg_reg[sel_reg] <= SFR_WDATA_IN[2:0];
      if (wr_cfg)
        cfg_v_reg[sel_reg] <= 1'b1;
      if (wr_ctl)
        mode_reg[sel_reg] <= SFR_WDATA_IN[3:2];
    end
  end
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);
  sequence s_rd(logic [7:0] ad);
    SFR_RD_IN && SFR_ADDR_IN == ad;
  endsequence
  chk_unmapped_zero: assert property (SFR_RD_IN && unmapped |=> SFR_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  chk_nak_cause: assert property (NAK_OUT |-> $past(FIU_IN.out_tok))
    else $error("nak without out token");
  chk_nak_stall: assert property (FIU_IN.out_tok && cfg_v_reg[FIU_EP_IN]
    && cfg_reg[FIU_EP_IN][CFG_STALL] |=> NAK_OUT) else $error("stalled token not refused");
  chk_sel_readback: assert property (s_rd(ADDR_EPSEL)
    |=> SFR_RDATA_OUT[EP_W-1:0] == $past(sel_reg)) else $error("select readback");
  chk_cfg_readback: assert property (s_rd(ADDR_EPCFG) ##0 cfg_v_reg[sel_reg]
    |=> SFR_RDATA_OUT[2:0] == $past(cfg_reg[sel_reg])) else $error("config readback");
  chk_mode_kept: assert property (s_rd(ADDR_CONTROL)
    |=> SFR_RDATA_OUT[3:2] == $past(mode_reg[sel_reg])) else $error("mode bits lost");
  chk_empty_full_excl: assert property (s_rd(ADDR_FLAGS)
    |=> !(SFR_RDATA_OUT[FLG_EMP] && SFR_RDATA_OUT[FLG_FULL])) else $error("empty and full");
  chk_single_index: assert property (s_rd(ADDR_FLAGS) ##0 cfg_v_reg[sel_reg]
    && cfg_reg[sel_reg][CFG_SPM] |=> !SFR_RDATA_OUT[FLG_FIF_HI]) else $error("single index");
endmodule
bind urx_fifo urx_fifo_checker chk_i (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
  .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN),
  .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT), .FIU_EP_IN(FIU_EP_IN),
  .FIU_IN(FIU_IN), .NAK_OUT(NAK_OUT));
`default_nettype wire

/* File: tb/usb_endpoint_receive_fifo_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_receive_fifo_status_bench;
  import urx_pkg::*;
  localparam logic [15:0] P_CNT = 16'h0040;
  localparam logic [15:0] P_ACK = 16'h0020;
  localparam logic [15:0] P_NAK = 16'h0010;
  localparam logic [15:0] P_SET = 16'h0008;
  localparam logic [15:0] P_OUT = 16'h0004;
  localparam logic [15:0] P_HS = 16'h0002;
  localparam logic [15:0] P_SOF = 16'h0001;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] a = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [EP_W-1:0] ep = '0;
  logic [7:0] rdata;
  logic nak;
  urx_fiu_s fiu;
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  urx_fiu_model fm (.clk_in(clk), .fiu_out(fiu));
  urx_fifo dut (.MCLK_IN(clk), .RESET_IN(rst), .SFR_ADDR_IN(a), .SFR_WR_IN(wr), .SFR_RD_IN(rd),
    .SFR_WDATA_IN(wd), .SFR_RDATA_OUT(rdata), .FIU_EP_IN(ep), .FIU_IN(fiu), .NAK_OUT(nak));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    #1;
    a = ad;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad);
    @(posedge clk);
    #1;
    a = ad;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] ad, input logic [7:0] m,
    input logic [7:0] e);
    rreg(ad);
    chk(n, rdata & m, e);
  endtask
  task automatic byt(input logic [7:0] d);
    fm.ev(urx_fiu_s'({1'b1, d, 7'b0}));
  endtask
  task automatic pls(input logic [15:0] v);
    fm.ev(urx_fiu_s'(v));
  endtask
  task automatic pkt(input int n, input logic [7:0] s);
    for (int i = 0; i < n; i++)
      byt(s + 8'(i));
    pls(P_CNT);
    pls(P_ACK);
  endtask
  task automatic sel(input logic [EP_W-1:0] n, input logic [7:0] cfg);
    wreg(ADDR_EPSEL, 8'(n));
    wreg(ADDR_EPCFG, cfg);
    ep = n;
  endtask
  // Polls the self-clearing flush bit rather than trusting a fixed delay
  task automatic flush();
    wreg(ADDR_CONTROL, 8'h84);
    for (int i = 0; i < 20; i++)
    begin
      rreg(ADDR_CONTROL);
      if (rdata[CTL_FLUSH] === 1'b0)
        break;
    end
    chk("flush_done", rdata & 8'h80, 8'h00);
    rc("flush_flags", ADDR_FLAGS, 8'hCF, FLG_RESET);
  endtask
  task automatic t_arm();
    rc("flags_rst", ADDR_FLAGS, 8'hCF, FLG_RESET);
    rc("ctl_rst", ADDR_CONTROL, 8'h9F, CTL_RESET);
    rc("unmapped", 8'hE0, 8'hFF, 8'h00);
    sel(0, 8'h00);
    pkt(3, 8'hA0);
    rc("pkt_in", ADDR_FLAGS, 8'hCC, 8'h40);
    for (int i = 0; i < 3; i++)
      rc("data", ADDR_DATA, 8'hFF, 8'hA0 + 8'(i));
    wreg(ADDR_CONTROL, 8'h14);
    rc("pkt_out", ADDR_FLAGS, 8'hC8, 8'h08);
    rc("under_data", ADDR_DATA, 8'hFF, 8'h00);
    rc("under_flag", ADDR_FLAGS, 8'h0A, 8'h0A);
    wreg(ADDR_FLAGS, 8'h00);
    rc("under_clr", ADDR_FLAGS, 8'h02, 8'h00);
    flush();
  endtask
  task automatic t_full();
    for (int i = 0; i < DEPTH; i++)
      byt(8'(i));
    rc("full", ADDR_FLAGS, 8'h0D, 8'h04);
    byt(8'hEE);
    rc("over", ADDR_FLAGS, 8'h05, 8'h05);
    flush();
  endtask
  task automatic t_manual();
    wreg(ADDR_CONTROL, 8'h00);
    byt(8'h01);
    byt(8'h02);
    wreg(ADDR_CONTROL, 8'h01);
    rc("rev", ADDR_FLAGS, 8'hC8, 8'h08);
    pkt(2, 8'h01);
    wreg(ADDR_CONTROL, 8'h02);
    rc("adv", ADDR_FLAGS, 8'hC8, 8'hC0);
    rc("ctl_clr", ADDR_CONTROL, 8'h03, 8'h00);
    flush();
    byt(8'h03);
    wreg(ADDR_CONTROL, 8'h05);
    rc("arm_rev", ADDR_FLAGS, 8'h08, 8'h00);
    flush();
  endtask
  task automatic t_iso();
    wreg(ADDR_CONTROL, 8'h0C);
    pkt(2, 8'h10);
    rc("iso_wait", ADDR_FLAGS, 8'hC0, 8'h00);
    pls(P_SOF);
    rc("iso_sof", ADDR_FLAGS, 8'hC0, 8'h40);
    for (int i = 0; i < DEPTH - 1; i++)
      byt(8'(i));
    rc("iso_ovf_wait", ADDR_FLAGS, 8'h05, 8'h04);
    pls(P_SOF);
    rc("iso_ovf", ADDR_FLAGS, 8'h01, 8'h01);
    flush();
  endtask
  task automatic t_setup();
    sel(2, 8'h05);
    rc("sel_rb", ADDR_EPSEL, 8'h03, 8'h02);
    rc("cfg_rb", ADDR_EPCFG, 8'h07, 8'h05);
    pls(P_SET);
    rc("start_overwrite_flag_set", ADDR_STATUS, 8'h20, 8'h20);
    pkt(1, 8'h55);
    pls(P_HS);
    rc("setup_set", ADDR_STATUS, 8'h60, 8'h40);
    pls(P_OUT);
    chk("nak_setup", {7'b0, nak}, 8'h01);
    wreg(ADDR_STATUS, 8'h10);
    pls(P_OUT);
    chk("nak_free", {7'b0, nak}, 8'h00);
    rc("spm", ADDR_FLAGS, 8'hC0, 8'h40);
    rc("setup_data", ADDR_DATA, 8'hFF, 8'h55);
    sel(0, 8'h00);
    rc("ep_apart", ADDR_FLAGS, 8'hC8, 8'h08);
  endtask
  task automatic t_stall();
    sel(3, 8'h02);
    pls(P_OUT);
    chk("nak_stall", {7'b0, nak}, 8'h01);
    byt(8'h77);
    pls(P_NAK);
    rc("void", ADDR_STATUS, 8'h04, 8'h04);
    rc("seq0", ADDR_STATUS, 8'h80, 8'h00);
    wreg(ADDR_STATUS, 8'h80);
    rc("seq_kept", ADDR_STATUS, 8'h80, 8'h00);
    wreg(ADDR_STATUS, 8'h88);
    rc("seq_set", ADDR_STATUS, 8'h80, 8'h80);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_arm();
    t_full();
    t_manual();
    t_iso();
    t_setup();
    t_stall();
    final_report();
  end
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
